// ==== tcr_pkg.sv ====
// tcr_pkg: register map, field layout, reset values and decode tables
// for the touch recalibration and threshold block.
// assumes: 8-bit register data, three sensor inputs.
package tcr_pkg;
   localparam int NUM_INPUTS = 3;
   localparam int DELTA_W = 8;
   localparam int ACC_W = 17;
   //////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [7:0] ADDR_RANGE_FLAGS = 8'h2e;
   localparam logic [7:0] ADDR_RECAL_SETUP = 8'h2f;
   localparam logic [7:0] ADDR_LEVEL_ONE = 8'h30;
   localparam logic [7:0] ADDR_LEVEL_TWO = 8'h31;
   localparam logic [7:0] ADDR_LEVEL_THREE = 8'h32;
   localparam logic [7:0] ADDR_NOISE_LEVEL = 8'h38;
   //////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [2:0] RST_RANGE_FLAGS = 3'h0;
   localparam logic [7:0] RST_RECAL_SETUP = 8'h8a;
   localparam logic [6:0] RST_TOUCH_LEVEL = 7'h40;
   localparam logic [1:0] RST_NOISE_LEVEL = 2'h1;
   //////////////////////////////////////////////////////////////////////
   // recalibration setup fields
   localparam int BIT_BROADCAST = 7;
   localparam int BIT_KEEP_INTD = 6;
   localparam int BIT_KEEP_NEG = 5;
   localparam int NEG_CNT_LSB = 3;
   localparam int CAL_CODE_LSB = 0;
   //////////////////////////////////////////////////////////////////////
   // negative delta trigger counts
   localparam logic [5:0] NEG_LIMIT_8 = 6'h08;
   localparam logic [5:0] NEG_LIMIT_16 = 6'h10;
   localparam logic [5:0] NEG_LIMIT_32 = 6'h20;
   localparam logic [5:0] NEG_LIMIT_OFF = 6'h00;
   //////////////////////////////////////////////////////////////////////
   // averaging shift (log2 samples): 16..256
   localparam logic [3:0] SHIFT_MIN = 4'h4;
   localparam logic [3:0] SHIFT_MAX = 4'h8;
   //////////////////////////////////////////////////////////////////////
   // update periods in sensing cycles
   localparam logic [12:0] PERIOD_1024 = 13'h0400;
   localparam logic [12:0] PERIOD_2048 = 13'h0800;
   localparam logic [12:0] PERIOD_4096 = 13'h1000;
   localparam logic [12:0] PERIOD_BASE = 13'h0010;
   //////////////////////////////////////////////////////////////////////
   // noise percent codes
   localparam logic [1:0] NOISE_25 = 2'h0;
   localparam logic [1:0] NOISE_37P5 = 2'h1;
   localparam logic [1:0] NOISE_50 = 2'h2;
   localparam logic [1:0] NOISE_62P5 = 2'h3;
endpackage

// ==== tcr_touch_recal.sv ====
// tcr_touch_recal: touch thresholds, noise screening, negative delta
// triggers and averaged base count updates for three sensor inputs.
// assumes: front end on mclk gives per-input delta samples, noise status,
// base count range status and a sensing cycle tick; host register port
// is a simple single-cycle write / registered read port.
//
// Operation
// - per-input flag shows base count out of range
// - any range flag sets summary status bit
// - broadcast bit copies input one level to all
// - levels two and three always writable directly
// - noise clears partial average unless kept
// - noise clears negative counter unless kept
// - negative count trigger 8/16/32 or off
// - setup code picks 16 to 256 averaged samples
// - setup code picks update interval in cycles
// - one setup code sets both sample count and update interval
// - recalibration settings shared by all inputs
// - three 7-bit touch levels, reset 40h
// - touch when delta exceeds its level
// - noise spikes kept out of averaging
// - noise check disable stops spike screening
// - noise level is percent of touch level
`timescale 1ns/1ps
module tcr_touch_recal (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // front end status
   input wire logic [2:0] base_out_range,
   input wire logic [2:0] noise_status,
   input wire logic noise_check_disable,
   input wire logic cycle_tick,
   // samples
   input wire logic [2:0] sample_valid,
   input wire logic [23:0] delta_flat,
   // results
   output logic range_fault_summary,
   output logic [2:0] touch_detected,
   output logic [2:0] noise_spike,
   output logic [2:0] neg_recal,
   output logic [2:0] recal_update,
   output logic [23:0] recal_value_flat
);
   ///////////////////////////////////////////////////////////////////////
   // decode functions
   function automatic logic [5:0] neg_limit(input logic [1:0] code);
      unique case (code)
         2'h0: neg_limit = tcr_pkg::NEG_LIMIT_8;
         2'h1: neg_limit = tcr_pkg::NEG_LIMIT_16;
         2'h2: neg_limit = tcr_pkg::NEG_LIMIT_32;
         2'h3: neg_limit = tcr_pkg::NEG_LIMIT_OFF;
      endcase
   endfunction

   function automatic logic [3:0] avg_shift(input logic [2:0] code);
      if (code > 3'h4) begin
         avg_shift = tcr_pkg::SHIFT_MAX;
      end else begin
         avg_shift = tcr_pkg::SHIFT_MIN + {1'b0, code};
      end
   endfunction

   function automatic logic [12:0] period(input logic [2:0] code);
      unique case (code)
         3'h5: period = tcr_pkg::PERIOD_1024;
         3'h6: period = tcr_pkg::PERIOD_2048;
         3'h7: period = tcr_pkg::PERIOD_4096;
         default: period = tcr_pkg::PERIOD_BASE << code;
      endcase
   endfunction

   function automatic logic [6:0] noise_level(input logic [6:0] thr,
                                              input logic [1:0] code);
      unique case (code)
         tcr_pkg::NOISE_25: noise_level = thr >> 2;
         tcr_pkg::NOISE_37P5: noise_level = (thr >> 2) + (thr >> 3);
         tcr_pkg::NOISE_50: noise_level = thr >> 1;
         tcr_pkg::NOISE_62P5: noise_level = (thr >> 1) + (thr >> 3);
      endcase
   endfunction

   ///////////////////////////////////////////////////////////////////////
   // register file
   logic [2:0] range_flags;
   logic [7:0] recal_setup;
   logic [6:0] thr_reg [3];
   logic [1:0] noise_code;

   wire wr_setup = reg_wr && (reg_addr == tcr_pkg::ADDR_RECAL_SETUP);
   wire wr_one = reg_wr && (reg_addr == tcr_pkg::ADDR_LEVEL_ONE);
   wire wr_two = reg_wr && (reg_addr == tcr_pkg::ADDR_LEVEL_TWO);
   wire wr_three = reg_wr && (reg_addr == tcr_pkg::ADDR_LEVEL_THREE);
   wire wr_noise = reg_wr && (reg_addr == tcr_pkg::ADDR_NOISE_LEVEL);
   wire broadcast = recal_setup[tcr_pkg::BIT_BROADCAST];
   wire keep_intd = recal_setup[tcr_pkg::BIT_KEEP_INTD];
   wire keep_neg = recal_setup[tcr_pkg::BIT_KEEP_NEG];
   wire [1:0] neg_code = recal_setup[tcr_pkg::NEG_CNT_LSB +: 2];
   wire [2:0] cal_code = recal_setup[tcr_pkg::CAL_CODE_LSB +: 3];
   wire [5:0] neg_lim = neg_limit(neg_code);
   wire [3:0] shift = avg_shift(cal_code);
   wire [8:0] sample_target = 9'h001 << shift;
   wire [12:0] upd_period = period(cal_code);
   wire [6:0] wdata7 = reg_wdata[6:0];
   wire [2:0] thr_load = {wr_three || (wr_one && broadcast),
                          wr_two || (wr_one && broadcast),
                          wr_one};

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         recal_setup <= tcr_pkg::RST_RECAL_SETUP;
         noise_code <= tcr_pkg::RST_NOISE_LEVEL;
      end else begin
         if (wr_setup) begin
            recal_setup <= reg_wdata;
         end
         if (wr_noise) begin
            noise_code <= reg_wdata[1:0];
         end
      end
   end

   // per-level load, broadcast from level one
   for (genvar t = 0; t < tcr_pkg::NUM_INPUTS; t++) begin : g_thr
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            thr_reg[t] <= tcr_pkg::RST_TOUCH_LEVEL;
         end else if (thr_load[t]) begin
            thr_reg[t] <= wdata7;
         end
      end
   end

   // range flags follow the front end; no write path exists
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         range_flags <= tcr_pkg::RST_RANGE_FLAGS;
         range_fault_summary <= 1'b0;
      end else begin
         range_flags <= base_out_range;
         range_fault_summary <= |base_out_range;
      end
   end

   logic [7:0] next_rdata;
   always_comb begin
      unique case (reg_addr)
         tcr_pkg::ADDR_RANGE_FLAGS: next_rdata = {5'h00, range_flags};
         tcr_pkg::ADDR_RECAL_SETUP: next_rdata = recal_setup;
         tcr_pkg::ADDR_LEVEL_ONE: next_rdata = {1'b0, thr_reg[0]};
         tcr_pkg::ADDR_LEVEL_TWO: next_rdata = {1'b0, thr_reg[1]};
         tcr_pkg::ADDR_LEVEL_THREE: next_rdata = {1'b0, thr_reg[2]};
         tcr_pkg::ADDR_NOISE_LEVEL: next_rdata = {6'h00, noise_code};
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // noise check disable arrives from a pin: two-stage synchroniser
   logic ncd_meta;
   logic ncd_sync;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ncd_meta <= 1'b0;
         ncd_sync <= 1'b0;
      end else begin
         ncd_meta <= noise_check_disable;
         ncd_sync <= ncd_meta;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // shared update interval counter in sensing cycles
   logic [12:0] cyc_cnt;
   wire period_end = cycle_tick && (cyc_cnt >= upd_period - 13'h0001);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cyc_cnt <= 13'h0000;
      end else if (period_end) begin
         cyc_cnt <= 13'h0000;
      end else if (cycle_tick) begin
         cyc_cnt <= cyc_cnt + 13'h0001;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // per-input sample processing
   for (genvar i = 0; i < tcr_pkg::NUM_INPUTS; i++) begin : g_in
      logic signed [tcr_pkg::ACC_W-1:0] acc;
      logic [8:0] acc_cnt;
      logic [5:0] neg_cnt;
      logic [7:0] avg;
      logic avg_valid;

      wire signed [7:0] d = delta_flat[8*i +: 8];
      wire signed [7:0] thr_s = {1'b0, thr_reg[i]};
      wire signed [7:0] noise_s = {1'b0, noise_level(thr_reg[i],
                                                     noise_code)};
      wire touch_now = sample_valid[i] && (d > thr_s);
      wire noise_now = sample_valid[i] && !touch_now && (d > noise_s)
                       && !ncd_sync;
      wire use_sample = sample_valid[i] && !noise_now;
      wire clr_intd = noise_status[i] && !keep_intd;
      wire clr_neg = noise_status[i] && !keep_neg;
      wire signed [tcr_pkg::ACC_W-1:0] sum = acc + tcr_pkg::ACC_W'(d);
      wire [8:0] next_cnt = acc_cnt + 9'h001;
      wire avg_done = use_sample && (next_cnt >= sample_target);
      wire [7:0] next_avg = 8'(sum >>> shift);
      wire neg_hit = sample_valid[i] && d[7];
      wire [5:0] next_neg = neg_cnt + 6'h01;
      wire neg_fire = neg_hit && (neg_lim != tcr_pkg::NEG_LIMIT_OFF)
                      && (next_neg == neg_lim);

      // averaging of non-noise samples
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            acc <= '0;
            acc_cnt <= 9'h000;
            avg <= 8'h00;
            avg_valid <= 1'b0;
         end else if (clr_intd) begin
            acc <= '0;
            acc_cnt <= 9'h000;
         end else if (avg_done) begin
            acc <= '0;
            acc_cnt <= 9'h000;
            avg <= next_avg;
            avg_valid <= 1'b1;
         end else if (use_sample) begin
            acc <= sum;
            acc_cnt <= next_cnt;
         end
      end

      // consecutive negative delta run
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            neg_cnt <= 6'h00;
         end else if (clr_neg || neg_fire) begin
            neg_cnt <= 6'h00;
         end else if (neg_hit) begin
            neg_cnt <= next_neg;
         end else if (sample_valid[i]) begin
            neg_cnt <= 6'h00;
         end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            touch_detected[i] <= 1'b0;
            noise_spike[i] <= 1'b0;
            neg_recal[i] <= 1'b0;
            recal_update[i] <= 1'b0;
         end else begin
            if (sample_valid[i]) begin
               touch_detected[i] <= touch_now;
               noise_spike[i] <= noise_now;
            end
            neg_recal[i] <= neg_fire;
            recal_update[i] <= period_end && avg_valid;
         end
      end

      assign recal_value_flat[8*i +: 8] = avg;

      AST_TOUCH: assert property (
         @(posedge mclk) disable iff (!rst_n)
         sample_valid[i] && (d > thr_s) |=> touch_detected[i])
         else $error("touch not reported above level");
      AST_NOISE_OFF: assert property (
         @(posedge mclk) disable iff (!rst_n)
         ncd_sync |=> !noise_spike[i] || !$past(sample_valid[i]))
         else $error("noise spike flagged while screening disabled");
      AST_SPIKE: assert property (
         @(posedge mclk) disable iff (!rst_n)
         sample_valid[i] && !ncd_sync && (d > noise_s) && (d <= thr_s)
         |=> noise_spike[i])
         else $error("noise spike not flagged");
      AST_INTD_CLR: assert property (
         @(posedge mclk) disable iff (!rst_n)
         noise_status[i] && !keep_intd |=> acc == 0 && acc_cnt == 0)
         else $error("partial average survived noise");
      AST_NEG_CLR: assert property (
         @(posedge mclk) disable iff (!rst_n)
         noise_status[i] && !keep_neg |=> neg_cnt == 6'h00)
         else $error("negative counter survived noise");
      AST_NEG_FIRE: assert property (
         @(posedge mclk) disable iff (!rst_n)
         neg_recal[i] |-> $past(neg_cnt) == $past(neg_lim) - 6'h01
                          && $past(neg_lim) != 6'h00)
         else $error("negative trigger at wrong count");
      AST_NEG_RUN: assert property (
         @(posedge mclk) disable iff (!rst_n)
         sample_valid[i] && !d[7] |=> neg_cnt == 6'h00)
         else $error("negative counter kept after positive sample");
   end

   ///////////////////////////////////////////////////////////////////////
   // checks on shared logic
   sequence s_bcast_write;
      wr_one && broadcast;
   endsequence

   sequence s_period_close;
      cycle_tick && (cyc_cnt >= upd_period - 13'h0001);
   endsequence

   AST_SUMMARY: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ##1 range_fault_summary == (|$past(base_out_range)))
      else $error("summary bit disagrees with flags");
   AST_FLAGS: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ##1 range_flags == $past(base_out_range))
      else $error("range flags do not track base status");
   AST_BCAST: assert property (
      @(posedge mclk) disable iff (!rst_n)
      s_bcast_write |=> thr_reg[0] == $past(wdata7)
         && thr_reg[1] == $past(wdata7)
         && thr_reg[2] == $past(wdata7))
      else $error("broadcast did not reach all levels");
   AST_DIRECT: assert property (
      @(posedge mclk) disable iff (!rst_n)
      wr_two |=> thr_reg[1] == $past(wdata7)
         && thr_reg[0] == $past(thr_reg[0]))
      else $error("direct level write misrouted");
   AST_RO_FLAGS: assert property (
      @(posedge mclk) disable iff (!rst_n)
      reg_wr && reg_addr == tcr_pkg::ADDR_RANGE_FLAGS
      |=> $stable(recal_setup) && $stable(noise_code))
      else $error("write to flag register changed state");
   AST_PERIOD: assert property (
      @(posedge mclk) disable iff (!rst_n)
      s_period_close ##0 g_in[0].avg_valid |=> recal_update[0]
      ##1 cyc_cnt == 13'h0000 || cycle_tick)
      else $error("update pulse missed at period end");
   AST_NO_EARLY: assert property (
      @(posedge mclk) disable iff (!rst_n)
      recal_update[0] |-> $past(cycle_tick)
      && $past(cyc_cnt) >= $past(upd_period) - 13'h0001)
      else $error("update pulse off the interval");
endmodule

// ==== tcr_pad_model.sv ====
// tcr_pad_model: three sensor pads with their sensing front end timing.
// assumes: bench asks for a sample on go with one delta per pad; mclk.
`timescale 1ns/1ps
module tcr_pad_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // bench requests
   input wire logic go,
   input wire logic [23:0] delta,
   input wire logic tick_en,
   // front end outputs
   output logic [2:0] sample_valid,
   output logic [23:0] delta_flat,
   output logic cycle_tick
);
   logic [1:0] div;
   ////////////////////////////////////////////////////////////////////
   // all pads sampled together; stale delta toggles inverted/true each idle clock
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sample_valid <= 3'h0;
         delta_flat <= 24'h0;
      end else if (go) begin
         sample_valid <= 3'h7;
         delta_flat <= delta;
      end else begin
         sample_valid <= 3'h0;
         delta_flat <= ~delta_flat;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // sensing cycle tick every fourth clock
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div <= 2'h0;
         cycle_tick <= 1'b0;
      end else begin
         div <= div + 2'h1;
         cycle_tick <= tick_en && (div == 2'h3);
      end
   end
endmodule

// ==== touch_recalibration_thresholds_bench.sv ====
// touch_recalibration_thresholds_bench: self-checking bench.
// assumes: tcr_touch_recal and tcr_pad_model; 20 MHz mclk.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
   miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module touch_recalibration_thresholds_bench;
   typedef struct packed {
      logic [1:0] nc;
      logic [7:0] d;
      logic t;
      logic n;
   } tcr_row_t;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] e;
   } tcr_reg_t;
   logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h0, reg_wdata = 8'h0, reg_rdata;
   logic [2:0] base_out_range = 3'h0, noise_status = 3'h0;
   logic noise_check_disable = 1'b0, go = 1'b0, tick_en = 1'b0;
   logic cycle_tick, range_fault_summary;
   logic [2:0] sample_valid, touch_detected, noise_spike, neg_recal;
   logic [2:0] recal_update;
   logic [23:0] dly = 24'h0, delta_flat, recal_value_flat;
   int miscompares = 0, cmp_count = 0, cyc = 0, nrc = 0, n0, t0;
   int per [3] = '{16, 32, 1024};
   logic [2:0] cod [3] = '{3'h0, 3'h1, 3'h5};
   tcr_reg_t regs [7] = '{'{8'h2e, 8'h00}, '{8'h2f, 8'h8a},
      '{8'h30, 8'h40}, '{8'h31, 8'h40}, '{8'h32, 8'h40},
      '{8'h38, 8'h01}, '{8'h33, 8'h00}};
   tcr_row_t rows [10] = '{'{2'h0, 8'h11, 1'h0, 1'h1},
      '{2'h0, 8'h10, 1'h0, 1'h0}, '{2'h1, 8'h19, 1'h0, 1'h1},
      '{2'h1, 8'h18, 1'h0, 1'h0}, '{2'h2, 8'h21, 1'h0, 1'h1},
      '{2'h2, 8'h20, 1'h0, 1'h0}, '{2'h3, 8'h29, 1'h0, 1'h1},
      '{2'h3, 8'h28, 1'h0, 1'h0}, '{2'h3, 8'h41, 1'h1, 1'h0},
      '{2'h3, 8'h40, 1'h0, 1'h1}};
   ////////////////////////////////////////////////////////////////////
   tcr_touch_recal dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .base_out_range(base_out_range),
      .noise_status(noise_status), .cycle_tick(cycle_tick),
      .noise_check_disable(noise_check_disable),
      .sample_valid(sample_valid), .delta_flat(delta_flat),
      .range_fault_summary(range_fault_summary),
      .touch_detected(touch_detected), .noise_spike(noise_spike),
      .neg_recal(neg_recal), .recal_update(recal_update),
      .recal_value_flat(recal_value_flat));
   tcr_pad_model pads (.mclk(mclk), .rst_n(rst_n), .go(go), .delta(dly),
      .tick_en(tick_en), .sample_valid(sample_valid),
      .delta_flat(delta_flat), .cycle_tick(cycle_tick));
   ////////////////////////////////////////////////////////////////////
   always #25 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      nrc <= nrc + $countones(neg_recal);
      if (cyc == 40000) begin
         miscompares++;
         results();
      end
   end
   task results();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      `CHK(reg_rdata, e)
   endtask
   task pad(input logic [23:0] d);
      @(posedge mclk);
      go <= 1'b1;
      dly <= d;
      @(posedge mclk);
      go <= 1'b0;
      @(posedge mclk);
      @(negedge mclk);
   endtask
   task negrun(input int n);
      repeat (n) pad({3{8'hf0}});
   endtask
   task noise();
      @(posedge mclk);
      noise_status <= 3'h7;
      @(posedge mclk);
      noise_status <= 3'h0;
   endtask
   task wait_upd();
      int i;
      i = 0;
      @(negedge mclk);
      while (recal_update === 3'h0 && i < 20000) begin
         @(negedge mclk);
         i++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      foreach (regs[i]) rchk(regs[i].a, regs[i].e);
      foreach (rows[i]) begin
         wr(8'h38, {6'h0, rows[i].nc});
         pad({3{rows[i].d}});
         `CHK(touch_detected, {3{rows[i].t}})
         `CHK(noise_spike, {3{rows[i].n}})
      end
      @(posedge mclk);
      noise_check_disable <= 1'b1;
      pad({3{8'h30}});
      `CHK(noise_spike, 3'h0)
      @(posedge mclk);
      base_out_range <= 3'h5;
      rchk(8'h2e, 8'h05);
      wr(8'h2e, 8'hff);
      rchk(8'h2e, 8'h05);
      `CHK(range_fault_summary, 1'b1)
      @(posedge mclk);
      base_out_range <= 3'h0;
      repeat (2) @(negedge mclk);
      `CHK(range_fault_summary, 1'b0)
      wr(8'h30, 8'hff);
      rchk(8'h31, 8'h7f);
      rchk(8'h32, 8'h7f);
      wr(8'h31, 8'h12);
      rchk(8'h30, 8'h7f);
      rchk(8'h31, 8'h12);
      wr(8'h2f, 8'h0a);
      wr(8'h30, 8'h55);
      rchk(8'h31, 8'h12);
      rchk(8'h30, 8'h55);
      for (int c = 0; c < 3; c++) begin
         wr(8'h2f, 8'(c << 3));
         pad(24'h0);
         n0 = nrc;
         negrun((8 << c) - 1);
         `CHK(nrc, n0)
         negrun(1);
         repeat (2) @(negedge mclk);
         `CHK(nrc, n0 + 3)
      end
      wr(8'h2f, 8'h00);
      n0 = nrc;
      negrun(12);
      negrun(3);
      `CHK(nrc, n0 + 3)
      pad(24'h0);
      negrun(4);
      pad(24'h0);
      negrun(7);
      noise();
      negrun(1);
      `CHK(nrc, n0 + 3)
      wr(8'h2f, 8'h60);
      pad(24'h0);
      negrun(7);
      noise();
      negrun(1);
      repeat (2) @(negedge mclk);
      `CHK(nrc, n0 + 6)
      wr(8'h2f, 8'h18);
      negrun(40);
      `CHK(nrc, n0 + 6)
      wr(8'h2f, 8'h00);
      repeat (32) pad({3{8'h10}});
      @(posedge mclk);
      tick_en <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         wr(8'h2f, {5'h0, cod[k]});
         wait_upd();
         t0 = cyc;
         wait_upd();
         `CHK(cyc - t0, per[k] * 4)
         `CHK(recal_update, 3'h7)
         `CHK(recal_value_flat, {3{8'h10}})
      end
      wr(8'h2f, 8'h01);
      noise();
      repeat (16) pad({3{8'h40}});
      `CHK(recal_value_flat, {3{8'h10}})
      repeat (16) pad(24'h0);
      `CHK(recal_value_flat, {3{8'h20}})
      results();
   end
endmodule
